// ### shared/ims_pkg.sv
// Constants, types and helpers shared by the two-wire mode sequencer
`default_nettype none
package ims_pkg;

  // Status codes
  localparam logic [7:0] ST_START         = 8'h08;
  localparam logic [7:0] ST_RSTART        = 8'h10;
  localparam logic [7:0] ST_AW_ACK        = 8'h18;
  localparam logic [7:0] ST_AW_NACK       = 8'h20;
  localparam logic [7:0] ST_DT_ACK        = 8'h28;
  localparam logic [7:0] ST_DT_NACK       = 8'h30;
  localparam logic [7:0] ST_ARB_LOST      = 8'h38;
  localparam logic [7:0] ST_AR_ACK        = 8'h40;
  localparam logic [7:0] ST_AR_NACK       = 8'h48;
  localparam logic [7:0] ST_RX_ACK        = 8'h50;
  localparam logic [7:0] ST_RX_NACK       = 8'h58;
  localparam logic [7:0] ST_SLV_ADDR      = 8'h60;
  localparam logic [7:0] ST_SLV_ADDR_LOST = 8'h68;
  localparam logic [7:0] ST_SLV_ACK       = 8'h80;
  localparam logic [7:0] ST_SLV_NACK      = 8'h88;
  localparam logic [7:0] ST_SLV_END       = 8'hA0;
  localparam logic [7:0] ST_IDLE          = 8'hF8;

  // Values after reset
  localparam logic [7:0] RST_STATUS = ST_IDLE;
  localparam logic [7:0] RST_DATA   = 8'h00;

  // Counts
  localparam logic [3:0] CNT_ACK  = 4'h8;
  localparam logic [3:0] CNT_END  = 4'h9;
  localparam logic [3:0] CNT_STEP = 4'h1;
  localparam logic [7:0] TMR_STEP = 8'h01;
  localparam logic [7:0] DIV_MIN  = 8'h01;

  // Phases of START and STOP generation
  localparam logic [1:0] STP_0 = 2'h0;
  localparam logic [1:0] STP_1 = 2'h1;
  localparam logic [1:0] STP_2 = 2'h2;

  // Field positions of the settings word sent to the link side
  localparam int CFG_W    = 42;
  localparam int CFG_CLR  = 41;
  localparam int CFG_STA  = 40;
  localparam int CFG_STO  = 39;
  localparam int CFG_ACK  = 38;
  localparam int CFG_DEN  = 37;
  localparam int CFG_BAUD = 29;
  localparam int CFG_TXD  = 21;
  localparam int CFG_ADA  = 14;
  localparam int CFG_ADB  = 7;
  localparam int CFG_ADC  = 0;

  typedef enum logic [2:0] {
    L_IDLE  = 3'b000,
    L_START = 3'b001,
    L_BYTE  = 3'b010,
    L_WAIT  = 3'b011,
    L_STOP  = 3'b100
  } ims_lstate_t;

  typedef enum logic [1:0] {
    N_ADDR = 2'b00,
    N_DATA = 2'b01,
    N_FREE = 2'b10
  } ims_next_t;

  // Bit-time divider, never below one cycle
  function automatic logic [7:0] ims_div(input logic [7:0] baud);
    ims_div = (baud < DIV_MIN) ? DIV_MIN : baud;
  endfunction : ims_div

  // Compare a received address byte with the three own addresses
  function automatic logic ims_match(input logic [7:0] sh, input logic [6:0] a,
                                     input logic [6:0] b, input logic [6:0] c);
    ims_match = (sh[7:1] == a) || (sh[7:1] == b) || (sh[7:1] == c);
  endfunction : ims_match

endpackage : ims_pkg
`default_nettype wire

// ### rtl/ims_sync2.sv
// Two flip-flop synchroniser for one level
`timescale 1ns/1ps
`default_nettype none
module ims_sync2 (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Level in and out
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_q;
  logic sync_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule : ims_sync2
`default_nettype wire

// ### rtl/ims_mode_seq.sv
// Byte-level mode sequencer of a two-wire serial controller
//
// How it works
// [R1] Software sets baud divider and divider enable before any master transfer.
// [R2] Start request waits for a free bus, sends START, posts 0x08, sets flag.
// [R3] Software drops start request, loads address byte, then clears the flag.
// [R4] Address with write direction acknowledged as master posts 0x18 and sets flag.
// [R5] On NACK while transmitting, software sends STOP or repeated START.
// [R6] Stop request plus flag clear sends STOP and releases the bus.
// [R7] A start request after the last byte gives repeated START, keeping the bus.
// [R8] Lost arbitration drops to unaddressed slave and posts 0x38.
// [R9] Address with read direction acknowledged as master posts 0x40 and sets flag.
// [R10] Master receive answers each byte ACK while acknowledge enable is set.
// [R11] Software clears the flag promptly after each received byte.
// [R12] Software clears acknowledge enable before the last read byte to NACK it.
// [R13] All-ones bytes mean a silent slave; software ends or restarts.
// [R14] Slave use needs own addresses and acknowledge enable; baud is ignored.
// [R15] Idle slave matching own address with write posts 0x60, acks, sets flag.
// [R16] Addressed slave acks each byte; flag clear releases the next byte.
// [R17] Acknowledge enable low: NACK next byte, unaddressed, data kept.
// [R18] Master losing in address then addressed for write posts 0x68 and acks.
// [R19] Addressed slave posts 0x80 on ACK, 0x88 on NACK, 0xA0 on STOP or START.
// [R20] After leaving addressed state, enable gates address match, start request restarts.
// [R21] Status reads 0xF8 whenever no event is pending.
// [R22] Every posted non-idle status sets the event flag.
// [R23] Serial clock is held low while the event flag is set, except after 0x38, 0x88 and 0xA0.
// [R24] Received bytes are answered ACK with acknowledge enable set, else NACK.
// [R25] Data sent, data received with ACK and with NACK post distinct codes.
// [R26] Each repeated START, address or data phase starts only on a flag clear.
`timescale 1ns/1ps
`default_nettype none
module ims_mode_seq
  import ims_pkg::*;
(
  // System clock and reset
  input  wire logic       SYS_CLK_I,
  input  wire logic       RST_N_I,
  // Link clock
  input  wire logic       LINK_CLK_I,
  // Software control
  input  wire logic       START_REQ_I,
  input  wire logic       STOP_REQUEST_I,
  input  wire logic       ACK_ENABLE_I,
  input  wire logic       FLAG_CLR_I,
  input  wire logic       DATA_LOAD_I,
  input  wire logic [7:0] DATA_IN_I,
  input  wire logic [7:0] BAUD_DIVIDER_I,
  input  wire logic       DIVIDER_ENABLE_I,
  input  wire logic [6:0] OWN_ADDRESS_A_I,
  input  wire logic [6:0] OWN_ADDRESS_B_I,
  input  wire logic [6:0] OWN_ADDRESS_C_I,
  // Software status
  output logic            EVENT_FLAG_O,
  output logic [7:0]      STATUS_O,
  output logic [7:0]      DATA_REG_O,
  // Two-wire pins
  input  wire logic       SCL_I,
  output logic            SCL_O,
  output logic            SCL_OE_O,
  input  wire logic       SDA_I,
  output logic            SDA_O,
  output logic            SDA_OE_O
);

  // System domain state
  logic             flag_q,     flag_d;
  logic [7:0]       stat_q,     stat_d;
  logic [7:0]       data_q,     data_d;
  logic             clr_pend_q, clr_pend_d;
  logic             req_tgl_q,  req_tgl_d;
  logic [CFG_W-1:0] cfg_bus_q,  cfg_bus_d;
  logic             ev_d1_q;
  logic             ev_s;
  logic             ack_s;
  logic             ev_new;
  logic             launch;

  // Link domain state
  ims_lstate_t      lst_q,      lst_d;
  ims_next_t        nx_q,       nx_d;
  logic [1:0]       stp_q,      stp_d;
  logic [7:0]       tmr_q,      tmr_d;
  logic [3:0]       cnt_q,      cnt_d;
  logic [7:0]       sh_q,       sh_d;
  logic             master_q,   master_d;
  logic             tx_q,       tx_d;
  logic             rd_q,       rd_d;
  logic             addr_q,     addr_d;
  logic             lost_q,     lost_d;
  logic             slv_q,      slv_d;
  logic             hit_q,      hit_d;
  logic             ackr_q,     ackr_d;
  logic             rs_q,       rs_d;
  logic             busy_q,     busy_d;
  logic             scl_low_q,  scl_low_d;
  logic             sda_low_q,  sda_low_d;
  logic             ev_tgl_q,   ev_tgl_d;
  logic [7:0]       ev_code_q,  ev_code_d;
  logic [7:0]       ev_data_q,  ev_data_d;
  logic             ev_dv_q,    ev_dv_d;
  logic [CFG_W-1:0] cfg_q,      cfg_d;
  logic             lack_tgl_q;
  logic             scl_d1_q;
  logic             sda_d1_q;
  logic             pin_lo_q;
  logic             lrst_n;
  logic             scl_s;
  logic             sda_s;
  logic             req_s;
  logic             req_chg;
  logic             clr_now;
  logic [CFG_W-1:0] cur;
  logic [7:0]       div;
  logic             scl_rise;
  logic             scl_fall;
  logic             start_det;
  logic             stop_det;
  logic             post;
  logic [7:0]       code;
  logic             dv;

  // Crossings
  ims_sync2 u_rst_sync (.clk_i(LINK_CLK_I), .rst_n_i(RST_N_I), .d_i(1'b1),       .q_o(lrst_n));
  ims_sync2 u_scl_sync (.clk_i(LINK_CLK_I), .rst_n_i(lrst_n),  .d_i(SCL_I),      .q_o(scl_s));
  ims_sync2 u_sda_sync (.clk_i(LINK_CLK_I), .rst_n_i(lrst_n),  .d_i(SDA_I),      .q_o(sda_s));
  ims_sync2 u_req_sync (.clk_i(LINK_CLK_I), .rst_n_i(lrst_n),  .d_i(req_tgl_q),  .q_o(req_s));
  ims_sync2 u_ack_sync (.clk_i(SYS_CLK_I),  .rst_n_i(RST_N_I), .d_i(lack_tgl_q), .q_o(ack_s));
  ims_sync2 u_ev_sync  (.clk_i(SYS_CLK_I),  .rst_n_i(RST_N_I), .d_i(ev_tgl_q),   .q_o(ev_s));

  // System side: flag, status, data register and settings handshake
  always_comb begin
    ev_new     = ev_s ^ ev_d1_q;
    launch     = (req_tgl_q == ack_s);
    flag_d     = flag_q;
    stat_d     = stat_q;
    data_d     = data_q;
    clr_pend_d = clr_pend_q;
    req_tgl_d  = req_tgl_q;
    cfg_bus_d  = cfg_bus_q;
    if (DATA_LOAD_I) begin
      data_d = DATA_IN_I;
    end
    if (FLAG_CLR_I) begin
      flag_d = 1'b0;
      stat_d = ST_IDLE; // [R21]
    end
    if (ev_new) begin
      flag_d = 1'b1; // [R22]
      stat_d = ev_code_q;
      if (ev_dv_q) begin
        data_d = ev_data_q;
      end
    end
    if (launch) begin
      cfg_bus_d  = {clr_pend_q, START_REQ_I, STOP_REQUEST_I, ACK_ENABLE_I, DIVIDER_ENABLE_I,
                    BAUD_DIVIDER_I, data_q, OWN_ADDRESS_A_I, OWN_ADDRESS_B_I, OWN_ADDRESS_C_I};
      req_tgl_d  = ~req_tgl_q;
      clr_pend_d = 1'b0;
    end
    if (FLAG_CLR_I && flag_q && !ev_new) begin
      clr_pend_d = 1'b1; // [R26]
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      flag_q     <= 1'b0;
      stat_q     <= RST_STATUS;
      data_q     <= RST_DATA;
      clr_pend_q <= 1'b0;
      req_tgl_q  <= 1'b0;
      cfg_bus_q  <= '0;
      ev_d1_q    <= 1'b0;
    end else begin
      flag_q     <= flag_d;
      stat_q     <= stat_d;
      data_q     <= data_d;
      clr_pend_q <= clr_pend_d;
      req_tgl_q  <= req_tgl_d;
      cfg_bus_q  <= cfg_bus_d;
      ev_d1_q    <= ev_s;
    end
  end

  // Link side: bus conditions and byte engine
  always_comb begin
    req_chg   = req_s ^ lack_tgl_q;
    cur       = req_chg ? cfg_bus_q : cfg_q;
    clr_now   = req_chg & cfg_bus_q[CFG_CLR];
    div       = ims_div(cur[CFG_BAUD +: 8]);
    scl_rise  = scl_s & ~scl_d1_q;
    scl_fall  = ~scl_s & scl_d1_q;
    start_det = scl_s & scl_d1_q & sda_d1_q & ~sda_s;
    stop_det  = scl_s & scl_d1_q & ~sda_d1_q & sda_s;
    lst_d = lst_q;  nx_d = nx_q;  stp_d = stp_q;  tmr_d = tmr_q;  cnt_d = cnt_q;
    sh_d = sh_q;  master_d = master_q;  tx_d = tx_q;  rd_d = rd_q;  addr_d = addr_q;
    lost_d = lost_q;  slv_d = slv_q;  hit_d = hit_q;  ackr_d = ackr_q;  rs_d = rs_q;
    scl_low_d = scl_low_q;  sda_low_d = sda_low_q;  cfg_d = cur;
    ev_tgl_d = ev_tgl_q;  ev_code_d = ev_code_q;  ev_data_d = ev_data_q;  ev_dv_d = ev_dv_q;
    post = 1'b0;  code = ST_IDLE;  dv = 1'b0;
    busy_d = start_det ? 1'b1 : (stop_det ? 1'b0 : busy_q);
    // Serial clock generation while owning a byte
    if (lst_q == L_BYTE && master_q) begin
      if (scl_low_q || scl_s) begin
        tmr_d = tmr_q + TMR_STEP;
        if (tmr_q >= div) begin
          scl_low_d = ~scl_low_q;
          tmr_d     = '0;
        end
      end else begin
        tmr_d = '0;
      end
    end
    case (lst_q)
      L_IDLE: begin
        scl_low_d = 1'b0;
        sda_low_d = 1'b0;
        master_d  = 1'b0;
        slv_d     = 1'b0;
        if (cur[CFG_STA] && cur[CFG_DEN] && !busy_q) begin // [R1] [R20]
          lst_d = L_START;  stp_d = STP_0;  tmr_d = '0;  rs_d = 1'b0; // [R2]
        end else if (start_det) begin
          lst_d = L_BYTE;  cnt_d = '0;  addr_d = 1'b1;  tx_d = 1'b0;  lost_d = 1'b0;
        end
      end
      L_START: begin
        tmr_d = tmr_q + TMR_STEP;
        case (stp_q)
          STP_0: begin
            sda_low_d = 1'b0;
            if (tmr_q >= div) begin
              scl_low_d = 1'b0;  stp_d = STP_1;  tmr_d = '0;
            end
          end
          STP_1: begin
            if (!(scl_s && sda_s)) begin
              tmr_d = '0; // [R2]
            end else if (tmr_q >= div) begin
              sda_low_d = 1'b1;  stp_d = STP_2;  tmr_d = '0;  busy_d = 1'b1;
            end
          end
          default: begin
            if (tmr_q >= div) begin
              scl_low_d = 1'b1;  master_d = 1'b1;  lost_d = 1'b0;  nx_d = N_ADDR;
              post = 1'b1;  code = rs_q ? ST_RSTART : ST_START; // [R2] [R7]
              lst_d = L_WAIT;
            end
          end
        endcase
      end
      L_WAIT: begin
        scl_low_d = (nx_q != N_FREE); // [R23]
        if (clr_now) begin // [R26]
          cnt_d = '0;  tmr_d = '0;  stp_d = STP_0;
          if (nx_q == N_FREE) begin
            lst_d = L_IDLE;
          end else if (master_q && cur[CFG_STO]) begin
            lst_d = L_STOP; // [R6]
          end else if (master_q && cur[CFG_STA]) begin
            lst_d = L_START;  rs_d = 1'b1; // [R7]
          end else if (master_q && (nx_q == N_ADDR || !rd_q)) begin
            lst_d = L_BYTE;  tx_d = 1'b1;  addr_d = (nx_q == N_ADDR); // [R3]
            sh_d  = cur[CFG_TXD +: 8];
            sda_low_d = ~cur[CFG_TXD + 7];
          end else begin
            lst_d = L_BYTE;  tx_d = 1'b0;  addr_d = 1'b0;  sda_low_d = 1'b0; // [R10] [R16]
            scl_low_d = master_q;
          end
        end
      end
      L_BYTE: begin
        if (!master_q && slv_q && (stop_det || start_det)) begin
          post = 1'b1;  code = ST_SLV_END;  slv_d = 1'b0;  lst_d = L_IDLE; // [R19]
        end else if (!master_q && !slv_q && stop_det) begin
          lst_d = L_IDLE;
        end else if (!master_q && !slv_q && start_det) begin
          cnt_d = '0;
        end else if (scl_rise) begin
          cnt_d = cnt_q + CNT_STEP;
          if (cnt_q < CNT_ACK) begin
            sh_d = {sh_q[6:0], sda_s};
            if (tx_q && master_q && !lost_q && !sda_low_q && !sda_s) begin
              lost_d = 1'b1;  sda_low_d = 1'b0; // [R8]
            end
          end else begin
            ackr_d = ~sda_s;
          end
        end else if (scl_fall && cnt_q < CNT_ACK && master_q && !lost_q && tx_q) begin
          sda_low_d = ~sh_q[7]; // [R4] [R25]
        end else if (scl_fall && cnt_q == CNT_ACK) begin
          hit_d = (!master_q || lost_q) && addr_q && !sh_q[0] && cur[CFG_ACK] &&
                  ims_match(sh_q, cur[CFG_ADA +: 7], cur[CFG_ADB +: 7], cur[CFG_ADC +: 7]);
          if (master_q && !lost_q) begin
            sda_low_d = !tx_q && cur[CFG_ACK]; // [R10] [R24]
          end else if (addr_q) begin
            sda_low_d = hit_d; // [R15] [R18] [R20]
          end else begin
            sda_low_d = slv_q && cur[CFG_ACK]; // [R16] [R17] [R24]
          end
        end else if (scl_fall && cnt_q == CNT_END) begin
          sda_low_d = 1'b0;
          scl_low_d = 1'b1; // [R23]
          lst_d = L_WAIT;
          nx_d  = N_DATA;
          post  = 1'b1;
          if (master_q && !lost_q && tx_q && addr_q) begin
            rd_d = sh_q[0];
            code = sh_q[0] ? (ackr_q ? ST_AR_ACK : ST_AR_NACK)
                           : (ackr_q ? ST_AW_ACK : ST_AW_NACK); // [R4] [R9]
          end else if (master_q && !lost_q && tx_q) begin
            code = ackr_q ? ST_DT_ACK : ST_DT_NACK; // [R5] [R25]
          end else if (master_q && !lost_q) begin
            code = ackr_q ? ST_RX_ACK : ST_RX_NACK; // [R13] [R25]
            dv = 1'b1;
          end else if (addr_q && hit_q) begin
            code = lost_q ? ST_SLV_ADDR_LOST : ST_SLV_ADDR; // [R15] [R18]
            master_d = 1'b0;  slv_d = 1'b1;  rd_d = 1'b0;
          end else if (lost_q) begin
            code = ST_ARB_LOST; // [R8]
            master_d = 1'b0;  scl_low_d = 1'b0;  lst_d = L_IDLE;
          end else if (slv_q && ackr_q) begin
            code = ST_SLV_ACK;  dv = 1'b1; // [R19]
          end else if (slv_q) begin
            code = ST_SLV_NACK; // [R17] [R19]
            slv_d = 1'b0;  scl_low_d = 1'b0;  lst_d = L_IDLE;
          end else begin
            post = 1'b0;  scl_low_d = 1'b0;  lst_d = L_IDLE; // [R14]
          end
        end
      end
      L_STOP: begin
        tmr_d = tmr_q + TMR_STEP;
        case (stp_q)
          STP_0: begin
            sda_low_d = 1'b1;
            if (tmr_q >= div) begin
              scl_low_d = 1'b0;  stp_d = STP_1;  tmr_d = '0;
            end
          end
          STP_1: begin
            if (!scl_s) begin
              tmr_d = '0;
            end else if (tmr_q >= div) begin
              sda_low_d = 1'b0;  stp_d = STP_2;  tmr_d = '0; // [R6]
            end
          end
          default: begin
            if (tmr_q >= div) begin
              master_d = 1'b0;  rd_d = 1'b0;  rs_d = 1'b0;  busy_d = 1'b0;
              lst_d = L_IDLE;
            end
          end
        endcase
      end
      default: begin
        lst_d = L_IDLE;
      end
    endcase
    if (post) begin
      ev_tgl_d  = ~ev_tgl_q;
      ev_code_d = code;
      ev_dv_d   = dv;
      ev_data_d = dv ? sh_q : ev_data_q; // [R17]
    end
  end

  always_ff @(posedge LINK_CLK_I or negedge lrst_n) begin
    if (!lrst_n) begin
      lst_q <= L_IDLE;  nx_q <= N_FREE;  stp_q <= STP_0;  tmr_q <= '0;  cnt_q <= '0;
      sh_q <= '0;  master_q <= 1'b0;  tx_q <= 1'b0;  rd_q <= 1'b0;  addr_q <= 1'b0;
      lost_q <= 1'b0;  slv_q <= 1'b0;  hit_q <= 1'b0;  ackr_q <= 1'b0;  rs_q <= 1'b0;
      busy_q <= 1'b0;  scl_low_q <= 1'b0;  sda_low_q <= 1'b0;
      ev_tgl_q <= 1'b0;  ev_code_q <= RST_STATUS;  ev_data_q <= RST_DATA;  ev_dv_q <= 1'b0;
      cfg_q <= '0;  lack_tgl_q <= 1'b0;  scl_d1_q <= 1'b0;  sda_d1_q <= 1'b0;
      pin_lo_q <= 1'b0;
    end else begin
      lst_q <= lst_d;  nx_q <= nx_d;  stp_q <= stp_d;  tmr_q <= tmr_d;  cnt_q <= cnt_d;
      sh_q <= sh_d;  master_q <= master_d;  tx_q <= tx_d;  rd_q <= rd_d;  addr_q <= addr_d;
      lost_q <= lost_d;  slv_q <= slv_d;  hit_q <= hit_d;  ackr_q <= ackr_d;  rs_q <= rs_d;
      busy_q <= busy_d;  scl_low_q <= scl_low_d;  sda_low_q <= sda_low_d;
      ev_tgl_q <= ev_tgl_d;  ev_code_q <= ev_code_d;  ev_data_q <= ev_data_d;
      ev_dv_q <= ev_dv_d;  cfg_q <= cfg_d;  lack_tgl_q <= req_s;
      scl_d1_q <= scl_s;  sda_d1_q <= sda_s;  pin_lo_q <= 1'b0;
    end
  end

  // Outputs
  assign EVENT_FLAG_O = flag_q;
  assign STATUS_O     = stat_q;
  assign DATA_REG_O   = data_q;
  assign SCL_O        = pin_lo_q;
  assign SCL_OE_O     = scl_low_q;
  assign SDA_O        = pin_lo_q;
  assign SDA_OE_O     = sda_low_q;

endmodule : ims_mode_seq
`default_nettype wire

// ### tb/ims_mode_seq_props.sv
// Port checks of the mode sequencer
`timescale 1ns/1ps
`default_nettype none
module ims_props
  import ims_pkg::*;
(
  // Clock, reset and software side
  input wire logic       SYS_CLK_I,
  input wire logic       RST_N_I,
  input wire logic       FLAG_CLR_I,
  input wire logic       DATA_LOAD_I,
  input wire logic [7:0] DATA_IN_I,
  input wire logic       EVENT_FLAG_O,
  input wire logic [7:0] STATUS_O,
  input wire logic [7:0] DATA_REG_O,
  // Pins
  input wire logic       SCL_O,
  input wire logic       SCL_OE_O,
  input wire logic       SDA_O,
  input wire logic       SDA_OE_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);
  logic hold;
  // Event that keeps the clock line stretched
  assign hold = EVENT_FLAG_O && !(STATUS_O inside {ST_SLV_NACK, ST_ARB_LOST, ST_SLV_END});
  a_flag_tracks_status: assert property (EVENT_FLAG_O == (STATUS_O != ST_IDLE))
    else $error("flag and status disagree");
  a_clear_to_idle: assert property (FLAG_CLR_I && hold |=> !EVENT_FLAG_O)
    else $error("flag clear not taken");
  a_scl_stretch: assert property (hold && $past(hold) |-> SCL_OE_O)
    else $error("clock line released during event");
  a_start_drives: assert property ($rose(EVENT_FLAG_O) && STATUS_O == ST_START
    |-> SDA_OE_O && SCL_OE_O)
    else $error("start posted without both lines low");
  a_phase_waits: assert property (hold [*8] ##1 hold |-> $stable(SDA_OE_O))
    else $error("data line moved while flag set");
  a_data_load: assert property (DATA_LOAD_I |=> DATA_REG_O == $past(DATA_IN_I))
    else $error("data register not loaded");
  a_status_holds: assert property (hold && !FLAG_CLR_I |=> $stable(STATUS_O))
    else $error("status moved without clear");
  a_pins_open_drain: assert property (!SCL_O && !SDA_O)
    else $error("pin driven high");
  c_addr_ack: cover property ($rose(EVENT_FLAG_O) && STATUS_O == ST_AW_ACK);
  c_rx_nack: cover property ($rose(EVENT_FLAG_O) && STATUS_O == ST_RX_NACK);
  c_rstart: cover property ($rose(EVENT_FLAG_O) && STATUS_O == ST_RSTART);
endmodule : ims_props
bind ims_mode_seq ims_props u_ims_props (.*);
`default_nettype wire

// ### tb/ims_slave_model.sv
// Behavioural slave on the two-wire bus
`timescale 1ns/1ps
`default_nettype none
module ims_slave_model #(
  parameter logic [6:0] ADDR  = 7'h2A,
  parameter logic [7:0] RDATA = 8'hC5
) (
  // Bus
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_low_o
);
  logic [7:0] sh;
  logic [3:0] cnt;
  logic       act, rd, adr, ack_n;
  initial begin
    sda_low_o = 1'b0;
    act = 1'b0;
    cnt = 4'h0;
  end
  always @(negedge sda_i) if (scl_i) begin
    act = 1'b1;
    adr = 1'b1;
    rd = 1'b0;
    cnt = 4'h0;
  end
  always @(posedge sda_i) if (scl_i) act = 1'b0;
  always @(posedge scl_i) if (act) begin
    if (cnt < 4'h8) sh = {sh[6:0], sda_i};
    else ack_n = sda_i;
    cnt = (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
  end
  // Changes only after the clock falls
  always @(negedge scl_i) if (act) begin
    sda_low_o = 1'b0;
    if (cnt == 4'h8) begin
      if (adr) begin
        adr = 1'b0;
        rd = sh[0];
        act = (sh[7:1] == ADDR);
        sda_low_o = act;
      end else sda_low_o = !rd;
    end else if (rd) begin
      if (cnt == 4'h0 && ack_n) act = 1'b0;
      else sda_low_o = !RDATA[4'h7 - cnt];
    end
  end
endmodule : ims_slave_model
`default_nettype wire

// ### tb/ims_mode_seq_tb.sv
// Self-checking bench of the mode sequencer
`timescale 1ns/1ps
`default_nettype none
module ims_mode_seq_tb;
  import ims_pkg::*;
  localparam logic [6:0] SLV  = 7'h2A;
  localparam logic [7:0] RDAT = 8'hC5;
  logic       clk, rst_n, lclk, sta, stop_request, aen, clr, ld, den, flag;
  logic       scl_o, scl_oe, sda_o, sda_oe, slv_low, m_scl_low, m_sda_low;
  logic [7:0] din, baud, stat, dreg;
  wire        scl = !(scl_oe || m_scl_low);
  wire        sda = !(sda_oe || slv_low || m_sda_low);
  int         n_mismatch, total_checks, cyc;
  ims_mode_seq u_ims_mode_seq (
    .SYS_CLK_I(clk), .RST_N_I(rst_n), .LINK_CLK_I(lclk), .START_REQ_I(sta),
    .STOP_REQUEST_I(stop_request), .ACK_ENABLE_I(aen), .FLAG_CLR_I(clr), .DATA_LOAD_I(ld),
    .DATA_IN_I(din), .BAUD_DIVIDER_I(baud), .DIVIDER_ENABLE_I(den),
    .OWN_ADDRESS_A_I(7'h11), .OWN_ADDRESS_B_I(7'h12), .OWN_ADDRESS_C_I(7'h13),
    .EVENT_FLAG_O(flag), .STATUS_O(stat), .DATA_REG_O(dreg), .SCL_I(scl),
    .SCL_O(scl_o), .SCL_OE_O(scl_oe), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_O(sda_oe));
  ims_slave_model #(.ADDR(SLV), .RDATA(RDAT)) u_ims_slave_model (
    .scl_i(scl), .sda_i(sda), .sda_low_o(slv_low));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wait_flag();
    for (int i = 0; i < 3000 && flag !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
  endtask : wait_flag
  task automatic clear_flag();
    repeat (20) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk) clr <= 1'b0;
    @(posedge clk);
    #1;
  endtask : clear_flag
  task automatic step(input logic do_ld, input logic [7:0] b, input logic [7:0] exp);
    @(posedge clk);
    din <= b;
    ld <= do_ld;
    @(posedge clk) ld <= 1'b0;
    clear_flag();
    chk("cleared status", ST_IDLE, stat);
    wait_flag();
    chk("scl held", 8'h00, {7'h0, scl});
    chk("status", exp, stat);
  endtask : step
  task automatic stop_bus();
    @(posedge clk) stop_request <= 1'b1;
    clear_flag();
    repeat (400) @(posedge clk);
    stop_request <= 1'b0;
    #1;
    chk("bus free", 8'h03, {6'h0, scl, sda});
    chk("no event", ST_IDLE, stat);
  endtask : stop_bus
  task automatic t_master();
    @(posedge clk) sta <= 1'b1;
    wait_flag();
    chk("start", ST_START, stat);
    @(posedge clk) sta <= 1'b0;
    step(1'b1, {SLV, 1'b0}, ST_AW_ACK);
    step(1'b1, 8'h5A, ST_DT_ACK);
    @(posedge clk) sta <= 1'b1;
    step(1'b0, 8'h00, ST_RSTART);
    @(posedge clk) sta <= 1'b0;
    step(1'b1, {SLV, 1'b1}, ST_AR_ACK);
    @(posedge clk) aen <= 1'b1;
    step(1'b0, 8'h00, ST_RX_ACK);
    chk("rx byte", RDAT, dreg);
    @(posedge clk) aen <= 1'b0;
    step(1'b0, 8'h00, ST_RX_NACK);
    chk("rx last", RDAT, dreg);
    stop_bus();
  endtask : t_master
  task automatic t_nack();
    @(posedge clk) sta <= 1'b1;
    wait_flag();
    chk("start again", ST_START, stat);
    @(posedge clk) sta <= 1'b0;
    step(1'b1, 8'h44, ST_AW_NACK);
    @(posedge clk) sta <= 1'b1;
    step(1'b0, 8'h00, ST_RSTART);
    @(posedge clk) sta <= 1'b0;
    step(1'b1, 8'h45, ST_AR_NACK);
    step(1'b0, 8'h00, ST_RX_NACK);
    chk("silent slave", 8'hFF, dreg);
    stop_bus();
  endtask : t_nack
  task automatic m_byte(input logic [7:0] b, output logic ack);
    logic [8:0] w;
    w = {b, 1'b1};
    for (int i = 8; i >= 0; i--) begin
      m_sda_low <= !w[i];
      repeat (10) @(posedge clk);
      m_scl_low <= 1'b0;
      @(posedge clk);
      while (scl !== 1'b1) @(posedge clk);
      repeat (10) @(posedge clk);
      ack = sda;
      m_scl_low <= 1'b1;
    end
  endtask : m_byte
  task automatic t_slave();
    logic ack;
    @(posedge clk) aen <= 1'b1;
    m_sda_low <= 1'b1;
    repeat (10) @(posedge clk);
    m_scl_low <= 1'b1;
    m_byte({7'h11, 1'b0}, ack);
    chk("slave addr ack", 8'h00, {7'h0, ack});
    wait_flag();
    chk("slave addressed", ST_SLV_ADDR, stat);
    clear_flag();
    m_byte(8'h3C, ack);
    wait_flag();
    chk("slave byte", ST_SLV_ACK, stat);
    chk("slave data", 8'h3C, dreg);
    @(posedge clk) aen <= 1'b0;
    clear_flag();
    m_byte(8'hA5, ack);
    chk("slave nack", 8'h01, {7'h0, ack});
    wait_flag();
    chk("slave status", ST_SLV_NACK, stat);
    chk("slave data kept", 8'h3C, dreg);
    clear_flag();
    m_sda_low <= 1'b1;
    repeat (10) @(posedge clk);
    m_scl_low <= 1'b0;
    repeat (10) @(posedge clk);
    m_sda_low <= 1'b0;
    repeat (10) @(posedge clk);
  endtask : t_slave
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    lclk = 1'b0;
    #3.7;
    forever #6 lclk = ~lclk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial begin
    {rst_n, sta, stop_request, aen, clr, ld, m_scl_low, m_sda_low} = 8'h00;
    den = 1'b1;
    baud = 8'h04;
    din = 8'h00;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    chk("reset status", ST_IDLE, stat);
    chk("reset flag", 8'h00, {7'h0, flag});
    chk("reset data", RST_DATA, dreg);
    chk("reset pins", 8'h00, {4'h0, scl_oe, sda_oe, scl_o, sda_o});
    t_master();
    t_nack();
    t_slave();
    end_of_test();
  end
endmodule : ims_mode_seq_tb
`default_nettype wire
